// *** hw/linear_motor_hall_limits.sv ***
// speed and ratio limit checks, self-cooling overload sum and hall decode
// assumes hall and feedback inputs synchronous to pclk and an apb master
module linear_motor_hall_limits
  import linmot_pkg::*;
#(
  parameter int          CTRL_DIV      = 100,
  parameter logic [31:0] PULSE_LIMIT_K = 32'h0001_86A0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  hall_in,
  input  wire logic [15:0] thrust_ref,
  input  wire logic [6:0]  feedback_speed,
  input  wire logic [7:0]  phase_angle_error,
  input  wire logic        display_select_key,
  output logic             monitor_line,
  output logic      [19:0] allowed_limit_monitor,
  output logic      [2:0]  hall_pattern_monitor,
  output logic             u_phase_edge,
  output logic             speed_alarm,
  output logic             ratio_alarm,
  output logic             overload_alarm,
  output logic             hall_fault_alarm,
  output logic             angle_alarm,
  output logic             irq
);

  // ****************************************
  // apb decode
  // ****************************************
  wire wr_en   = psel && penable && pwrite;
  wire hit_ctl = paddr == CTRL_OFS;
  wire hit_mot = paddr == MOTOR_OFS;
  wire hit_rat = paddr == RATIO_OFS;
  wire hit_rtd = paddr == RATED_OFS;
  wire hit_ovl = paddr == OVL_OFS;
  wire hit_mon = paddr == MONITOR_OFS;
  wire hit_hal = paddr == HALL_OFS;
  wire hit_sts = paddr == STATUS_OFS;
  wire hit_msk = paddr == MASK_OFS;
  wire mapped  = hit_ctl | hit_mot | hit_rat | hit_rtd | hit_ovl | hit_mon | hit_hal
                 | hit_sts | hit_msk;

  logic [6:0]            max_set_q;
  logic                  basis_q;
  logic                  order_q;
  logic                  conn_q;
  logic [6:0]            motor_max_q;
  logic [6:0]            cool_q;
  logic [15:0]           ratio_q;
  logic [15:0]           rated_q;
  logic [31:0]           ovl_level_q;
  logic [NUM_EVENTS-1:0] status_q;
  logic [NUM_EVENTS-1:0] mask_q;
  logic [2:0]            pattern_q;
  logic                  u_conf_q;

  wire [6:0] wr_speed = pwdata[6:0];
  wire [6:0] wr_cool  = pwdata[COOL_LSB+:7];
  wire speed_ok = (wr_speed >= SPEED_MIN) && (wr_speed <= SPEED_MAX);
  wire cool_ok  = wr_cool <= COOL_MAX;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = !(psel && penable) ? 32'h0000_0000 :
                   hit_ctl ? {21'h00_0000, conn_q, order_q, basis_q, 1'b0, max_set_q} :
                   hit_mot ? {17'h0_0000, cool_q, 1'b0, motor_max_q} :
                   hit_rat ? {16'h0000, ratio_q} :
                   hit_rtd ? {16'h0000, rated_q} :
                   hit_ovl ? ovl_level_q :
                   hit_mon ? {11'h000, monitor_line, allowed_limit_monitor} :
                   hit_hal ? {28'h000_0000, u_conf_q, pattern_q} :
                   hit_sts ? {27'h000_0000, status_q} :
                   hit_msk ? {27'h000_0000, mask_q} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_set_q   <= SPEED_RESET;
      basis_q     <= 1'b0;
      order_q     <= 1'b0;
      conn_q      <= 1'b1;
    end else if (wr_en && hit_ctl) begin
      if (speed_ok) begin
        max_set_q <= wr_speed;
      end
      basis_q     <= pwdata[CTRL_BASIS_BIT];
      order_q     <= pwdata[CTRL_ORDER_BIT];
      conn_q      <= pwdata[CTRL_CONN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_max_q <= MOTOR_MAX_RESET;
      cool_q      <= 7'h00;
      ratio_q     <= 16'h0000;
      rated_q     <= 16'h0000;
      ovl_level_q <= 32'hFFFF_FFFF;
      mask_q      <= '0;
    end else if (wr_en) begin
      if (hit_mot) begin
        motor_max_q <= pwdata[6:0];
      end
      if (hit_mot && cool_ok) begin
        cool_q      <= wr_cool;
      end
      if (hit_rat) begin
        ratio_q     <= pwdata[15:0];
      end
      if (hit_rtd) begin
        rated_q     <= pwdata[15:0];
      end
      if (hit_ovl) begin
        ovl_level_q <= pwdata;
      end
      if (hit_msk) begin
        mask_q      <= pwdata[NUM_EVENTS-1:0];
      end
    end
  end

  // ****************************************
  // control cycle tick
  // ****************************************
  localparam int TW = $clog2(CTRL_DIV + 1);
  logic [TW-1:0] tick_cnt_q;
  wire           tick = tick_cnt_q == TW'(CTRL_DIV - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // ****************************************
  // limit checks
  // ****************************************
  wire [22:0] ratio_load = ratio_q * max_set_q;
  wire speed_over = max_set_q > motor_max_q;
  wire ratio_over = {9'h000, ratio_load} > PULSE_LIMIT_K;
  wire angle_over = phase_angle_error > ANGLE_LIMIT_DEG;

  // ****************************************
  // allowable speed or ratio divider
  // ****************************************
  div_state_type div_state_q;
  logic [31:0]   rem_q;
  logic [31:0]   quot_q;
  logic [15:0]   divisor_q;
  logic [5:0]    bit_cnt_q;
  logic [15:0]   allow_q;

  wire [15:0] divisor_d = basis_q ? ratio_q : {9'h000, max_set_q};
  wire [32:0] rem_shift = {rem_q, quot_q[31]};
  wire        rem_ge    = rem_shift >= {17'h0_0000, divisor_q};
  wire [32:0] rem_sub   = rem_shift - {17'h0_0000, divisor_q};
  wire [15:0] quot_sat  = (|quot_q[31:16]) ? 16'hFFFF : quot_q[15:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_state_q <= DIV_IDLE;
      rem_q       <= '0;
      quot_q      <= '0;
      divisor_q   <= '0;
      bit_cnt_q   <= '0;
      allow_q     <= '0;
    end else begin
      unique case (div_state_q)
        DIV_IDLE: begin
          rem_q       <= '0;
          quot_q      <= PULSE_LIMIT_K;
          divisor_q   <= divisor_d;
          bit_cnt_q   <= '0;
          div_state_q <= DIV_RUN;
        end
        DIV_RUN: begin
          rem_q       <= rem_ge ? rem_sub[31:0] : rem_shift[31:0];
          quot_q      <= {quot_q[30:0], rem_ge};
          bit_cnt_q   <= bit_cnt_q + 1'b1;
          if (bit_cnt_q == 6'h1F) begin
            div_state_q <= DIV_DONE;
          end
        end
        DIV_DONE: begin
          allow_q     <= (divisor_q == 16'h0000) ? 16'hFFFF : quot_sat;
          div_state_q <= DIV_IDLE;
        end
        default: div_state_q <= DIV_IDLE;
      endcase
    end
  end

  // ****************************************
  // monitor lines s and p
  // ****************************************
  function automatic logic [19:0] to_bcd(input logic [15:0] bin);
    logic [35:0] s;
    s = {20'h0_0000, bin};
    for (int i = 0; i < 16; i++) begin
      for (int j = 0; j < 5; j++) begin
        if (s[16+4*j+:4] > 4'h4) begin
          s[16+4*j+:4] = s[16+4*j+:4] + 4'h3;
        end
      end
      s = {s[34:0], 1'b0};
    end
    return s[35:16];
  endfunction : to_bcd

  logic key_q;
  logic line_q;
  wire  key_press = display_select_key && !key_q;
  wire [15:0] s_value = basis_q ? allow_q : {9'h000, max_set_q};
  wire [15:0] p_value = basis_q ? ratio_q : allow_q;
  wire [15:0] mon_value = line_q ? p_value : s_value;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q                 <= 1'b0;
      line_q                <= 1'b0;
      allowed_limit_monitor <= '0;
    end else begin
      key_q                 <= display_select_key;
      line_q                <= line_q ^ key_press;
      allowed_limit_monitor <= to_bcd(mon_value);
    end
  end

  assign monitor_line = line_q;

  // ****************************************
  // self-cooling overload sum
  // ****************************************
  logic signed [49:0] acc_q;
  wire [6:0]  fb_clip  = (feedback_speed > max_set_q) ? max_set_q : feedback_speed;
  wire [13:0] full_num = max_set_q * PCT_SCALE;
  wire [13:0] d_num    = full_num - 14'(fb_clip) * 14'(cool_q);
  wire [31:0] t_sq     = thrust_ref * thrust_ref;
  wire [31:0] r_sq     = rated_q * rated_q;
  wire signed [49:0] term = $signed({4'h0, 46'(t_sq) * 46'(d_num)})
                          - $signed({4'h0, 46'(r_sq) * 46'(full_num)});
  wire signed [49:0] acc_sum = acc_q + term;
  wire signed [49:0] ovl_lim = $signed({4'h0, 46'(ovl_level_q) * 46'(full_num)});
  wire ovl_hit = ovl_lim <= acc_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= '0;
    end else if (tick) begin
      acc_q <= acc_sum[49] ? '0 : acc_sum;
    end
  end

  // ****************************************
  // hall decode and filter
  // ****************************************
  logic bad_q;
  logic u_pend_q;
  wire [2:0] hall_uvw = order_q ? {hall_in[2], hall_in[0], hall_in[1]} : hall_in;
  wire hall_bad = conn_q && (hall_uvw == 3'h0 || hall_uvw == 3'h7);
  wire hall_twice = tick && hall_bad && bad_q;
  wire u_moved = hall_uvw[2] != u_conf_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pattern_q    <= 3'h0;
      bad_q        <= 1'b0;
      u_pend_q     <= 1'b0;
      u_conf_q     <= 1'b0;
      u_phase_edge <= 1'b0;
    end else begin
      u_phase_edge <= 1'b0;
      if (tick) begin
        bad_q <= hall_bad;
        if (!hall_bad) begin
          pattern_q <= hall_uvw;
          u_pend_q  <= u_moved && !u_pend_q;
          if (u_moved && u_pend_q) begin
            u_conf_q     <= hall_uvw[2];
            u_phase_edge <= 1'b1;
          end
        end
      end
    end
  end

  assign hall_pattern_monitor = pattern_q;

  // ****************************************
  // alarms, status and interrupt
  // ****************************************
  wire [NUM_EVENTS-1:0] ev_set = {angle_over, hall_twice, ovl_hit, ratio_over, speed_over};
  wire [NUM_EVENTS-1:0] ev_clr = (wr_en && hit_sts) ? pwdata[NUM_EVENTS-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q         <= '0;
      speed_alarm      <= 1'b0;
      ratio_alarm      <= 1'b0;
      overload_alarm   <= 1'b0;
      hall_fault_alarm <= 1'b0;
      angle_alarm      <= 1'b0;
    end else begin
      status_q         <= (status_q & ~ev_clr) | ev_set;
      speed_alarm      <= speed_over;
      ratio_alarm      <= ratio_over;
      overload_alarm   <= ovl_hit;
      hall_fault_alarm <= hall_fault_alarm | hall_twice;
      angle_alarm      <= angle_over;
    end
  end

  assign irq = |(status_q & mask_q);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_key_down;
    display_select_key && !key_q;
  endsequence

  sequence s_bad_pair;
    tick && hall_bad && bad_q;
  endsequence

  a_speed_in_range: assert property (
    max_set_q >= SPEED_MIN && max_set_q <= SPEED_MAX)
    else $error("speed setting left its range");

  a_speed_alarm_set: assert property (
    (max_set_q > motor_max_q) |=> speed_alarm && status_q[EV_SPEED])
    else $error("speed alarm missing");

  a_basis_source: assert property (
    (presetn && div_state_q == DIV_IDLE) |=> divisor_q == $past(divisor_d))
    else $error("divider took the wrong basis");

  a_ratio_alarm_set: assert property (
    ratio_over |=> ratio_alarm ##0 status_q[EV_RATIO])
    else $error("ratio alarm missing");

  a_monitor_value: assert property (
    presetn |=> allowed_limit_monitor == to_bcd($past(mon_value)))
    else $error("monitor digits wrong");

  a_key_toggle: assert property (
    s_key_down |=> monitor_line != $past(monitor_line) ##1 !key_press)
    else $error("display key did not toggle");

  a_overload_trip: assert property (
    ovl_hit |=> overload_alarm && status_q[EV_OVL])
    else $error("overload alarm missing");

  a_cool_factor: assert property (
    d_num <= full_num)
    else $error("cooling factor above one");

  a_hall_discard: assert property (
    (tick && hall_bad) |=> $stable(pattern_q))
    else $error("invalid hall pattern taken");

  a_hall_fault: assert property (
    s_bad_pair |=> hall_fault_alarm && status_q[EV_HALL])
    else $error("hall fault alarm missing");

  a_u_edge_twice: assert property (
    u_phase_edge |-> $past(u_pend_q) && $past(tick))
    else $error("u edge taken on one reading");

  a_angle_limit: assert property (
    (presetn && phase_angle_error > ANGLE_LIMIT_DEG) |=> angle_alarm)
    else $error("angle alarm missing");

  a_tick_single: assert property (
    tick |=> !tick [*2])
    else $error("control tick too frequent");

endmodule : linear_motor_hall_limits

// *** hw/linmot_pkg.sv ***
// constants for the linear motor limit, overload and hall sensor logic
// assumes one 100 MHz control clock and an apb master for the registers
package linmot_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] MOTOR_OFS   = 8'h04;
  localparam logic [7:0] RATIO_OFS   = 8'h08;
  localparam logic [7:0] RATED_OFS   = 8'h0C;
  localparam logic [7:0] OVL_OFS     = 8'h10;
  localparam logic [7:0] MONITOR_OFS = 8'h14;
  localparam logic [7:0] HALL_OFS    = 8'h18;
  localparam logic [7:0] STATUS_OFS  = 8'h1C;
  localparam logic [7:0] MASK_OFS    = 8'h20;

  // ****************************************
  // fields, ranges and reset values
  // ****************************************
  localparam logic [6:0] SPEED_MIN       = 7'h01;
  localparam logic [6:0] SPEED_MAX       = 7'h64;
  localparam logic [6:0] SPEED_RESET     = 7'h32;
  localparam logic [6:0] MOTOR_MAX_RESET = 7'h64;
  localparam logic [6:0] COOL_MAX        = 7'h64;
  localparam logic [6:0] PCT_SCALE       = 7'h64;
  localparam logic [7:0] ANGLE_LIMIT_DEG = 8'h28;
  localparam int         CTRL_BASIS_BIT  = 8;
  localparam int         CTRL_ORDER_BIT  = 9;
  localparam int         CTRL_CONN_BIT   = 10;
  localparam int         COOL_LSB        = 8;
  localparam int         MON_LINE_BIT    = 20;
  localparam int         NUM_EVENTS      = 5;
  localparam int         EV_SPEED        = 0;
  localparam int         EV_RATIO        = 1;
  localparam int         EV_OVL          = 2;
  localparam int         EV_HALL         = 3;
  localparam int         EV_ANGLE        = 4;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'b00,
    DIV_RUN  = 2'b01,
    DIV_DONE = 2'b11
  } div_state_type;

endpackage : linmot_pkg

// *** testbench/hall_sensor_model.sv ***
// far-side model: hall lines, thrust reference, speed feedback, angle error
// assumes one bench process calls its tasks, synchronous to pclk
module hall_sensor_model (
  input  wire logic        pclk,
  output logic      [2:0]  hall_in,
  output logic      [15:0] thrust_ref,
  output logic      [6:0]  feedback_speed,
  output logic      [7:0]  phase_angle_error
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hall_in = 3'h5;
    thrust_ref = 16'h0000;
    feedback_speed = 7'h00;
    phase_angle_error = 8'h00;
  end

  // ****************************************
  // slow answer: level held until the next call
  // ****************************************
  task automatic put(input logic [2:0] h);
    @(posedge pclk);
    hall_in <= h;
  endtask : put

  // prompt answer: glitch held for n cycles, then the old pattern again
  task automatic glitch(input logic [2:0] h, input int n);
    logic [2:0] old;
    old = hall_in;
    @(posedge pclk);
    hall_in <= h;
    repeat (n) @(posedge pclk);
    hall_in <= old;
  endtask : glitch

  task automatic load(input logic [15:0] t, input logic [6:0] v, input logic [7:0] a);
    @(posedge pclk);
    thrust_ref <= t;
    feedback_speed <= v;
    phase_angle_error <= a;
  endtask : load
endmodule : hall_sensor_model

// *** testbench/tb.sv ***
// self-checking bench for linear_motor_hall_limits with an apb master
// assumes a 4-cycle control tick and the package register map
module tb
  import linmot_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  hall_in;
  logic [15:0] thrust_ref;
  logic [6:0]  feedback_speed;
  logic [7:0]  phase_angle_error;
  logic        key;
  logic        monitor_line;
  logic [19:0] allowed_limit_monitor;
  logic [2:0]  hall_pattern_monitor;
  logic        u_phase_edge;
  logic        speed_alarm;
  logic        ratio_alarm;
  logic        overload_alarm;
  logic        hall_fault_alarm;
  logic        angle_alarm;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          fails;
  int          n_checks;
  int          n_edge;

  linear_motor_hall_limits #(.CTRL_DIV(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hall_in(hall_in), .thrust_ref(thrust_ref),
    .feedback_speed(feedback_speed), .phase_angle_error(phase_angle_error),
    .display_select_key(key), .monitor_line(monitor_line),
    .allowed_limit_monitor(allowed_limit_monitor),
    .hall_pattern_monitor(hall_pattern_monitor), .u_phase_edge(u_phase_edge),
    .speed_alarm(speed_alarm), .ratio_alarm(ratio_alarm),
    .overload_alarm(overload_alarm), .hall_fault_alarm(hall_fault_alarm),
    .angle_alarm(angle_alarm), .irq(irq)
  );

  hall_sensor_model m (
    .pclk(pclk), .hall_in(hall_in), .thrust_ref(thrust_ref),
    .feedback_speed(feedback_speed), .phase_angle_error(phase_angle_error)
  );

  // ****************************************
  // shared tasks and reference model
  // ****************************************
  always @(posedge pclk) if (u_phase_edge === 1'b1) n_edge++;

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_out

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    if (i == 16) begin
      fails++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
    apb(1'b0, a, 32'h0000_0000);
    chk_out(rd & mk, e);
  endtask : chk_reg

  task automatic reset_dut();
    presetn <= 1'b0;
    cyc(20);
    presetn <= 1'b1;
    cyc(2);
  endtask : reset_dut

  task automatic press();
    key <= 1'b1;
    cyc(2);
    key <= 1'b0;
    cyc(4);
  endtask : press

  function automatic logic [19:0] bcd(input int v);
    logic [19:0] r;
    r = 20'h0_0000;
    for (int k = 0; k < 5; k++) begin
      r[4*k +: 4] = 4'(v % 10);
      v = v / 10;
    end
    return r;
  endfunction : bcd

  // overload run with speed setting 50 and rated thrust 30, level in units of thrust^2
  task automatic ovl(input int t, input int v, input int c);
    longint per;
    longint lv;
    int     n;
    lv = 1000 + $urandom_range(3000);
    m.load(16'h0000, 7'h00, 8'h00);
    cyc(40);
    chk_out(overload_alarm, 0);
    wr(MOTOR_OFS, 32'(c * 256 + 100));
    wr(OVL_OFS, 32'(lv));
    per = longint'(t) * t * (5000 - v * c) - 900 * 5000;
    m.load(16'(t), 7'(v), 8'h00);
    if (per <= 0) begin
      cyc(60);
      chk_out(overload_alarm, 0);
    end else begin
      n = int'((lv * 5000 + per - 1) / per);
      cyc((n - 1) * 4);
      chk_out(overload_alarm, 0);
      cyc(10);
      chk_out(overload_alarm, 1);
    end
  endtask : ovl

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int          sv[4] = '{0, 101, 1, 100};
    int          spd;
    int          rt;
    int          lm;
    int          e;
    int          uq;
    logic [2:0]  h;
    logic [2:0]  mp;
    logic [2:0]  mon;
    void'($urandom(12));
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'($urandom);
    pwdata = $urandom;
    key = 1'b0;
    reset_dut();
    chk_reg(CTRL_OFS, 32'h0000_0432, 32'h0000_077F);
    chk_reg(MOTOR_OFS, 32'h0000_0064, 32'h0000_007F);
    chk_reg(OVL_OFS, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk_out({31'h0, err}, 1);
    chk_out(rd, 0);
    spd = 50;
    foreach (sv[i]) begin
      wr(CTRL_OFS, 32'(1024 + sv[i]));
      if (sv[i] >= 1 && sv[i] <= 100) spd = sv[i];
      chk_reg(CTRL_OFS, 32'(spd), 32'h0000_007F);
    end
    wr(MOTOR_OFS, 32'h0000_0014);
    wr(CTRL_OFS, 32'h0000_0415);
    cyc(3);
    chk_out(speed_alarm, 1);
    chk_out(irq, 0);
    wr(MASK_OFS, 32'h0000_0001);
    cyc(2);
    chk_out(irq, 1);
    wr(CTRL_OFS, 32'h0000_0414);
    cyc(3);
    chk_out(speed_alarm, 0);
    wr(STATUS_OFS, 32'h0000_0001);
    cyc(2);
    chk_out(irq, 0);
    chk_reg(STATUS_OFS, 32'h0000_0000, 32'h0000_0001);
    for (rt = 5001; rt >= 5000; rt--) begin
      wr(RATIO_OFS, 32'(rt));
      cyc(3);
      chk_out(ratio_alarm, 32'(rt * 20 > 100000));
    end
    lm = 0;
    for (int b = 0; b < 2; b++) begin
      rt = b ? 4000 : 5000;
      wr(CTRL_OFS, 32'(1024 + b * 256 + 20));
      wr(RATIO_OFS, 32'(rt));
      cyc(100);
      for (int k = 0; k < 2; k++) begin
        e = lm ? (b ? rt : 100000 / 20) : (b ? 100000 / rt : 20);
        chk_out(allowed_limit_monitor, bcd(e));
        chk_reg(MONITOR_OFS, {11'h0, lm[0], bcd(e)}, 32'h001F_FFFF);
        press();
        lm = 1 - lm;
        chk_out(monitor_line, lm);
      end
    end
    m.put(3'h1);
    cyc(20);
    e = n_edge;
    uq = 0;
    mon = 3'h1;
    for (int o = 0; o < 2; o++) begin
      wr(CTRL_OFS, 32'(1024 + o * 512 + 20));
      for (int i = 0; i < 10; i++) begin
        h = (i < 6) ? 3'(i + 1) : 3'(1 + $urandom_range(5));
        mp = o ? {h[2], h[0], h[1]} : h;
        m.put(h);
        cyc(16);
        if (mp[2] != uq[0]) e++;
        uq = mp[2];
        mon = mp;
        chk_out(hall_pattern_monitor, mon);
        chk_out(n_edge, e);
      end
    end
    wr(CTRL_OFS, 32'h0000_0414);
    m.put(3'h1);
    cyc(16);
    if (uq != 0) e++;
    m.glitch(3'h5, 4);
    cyc(16);
    chk_out(n_edge, e);
    m.glitch(3'h0, 4);
    cyc(16);
    chk_out(hall_fault_alarm, 0);
    chk_out(hall_pattern_monitor, 1);
    wr(CTRL_OFS, 32'h0000_0014);
    m.put(3'h7);
    cyc(16);
    chk_out(hall_pattern_monitor, 7);
    wr(CTRL_OFS, 32'h0000_0414);
    cyc(16);
    chk_out(hall_pattern_monitor, 7);
    chk_out(hall_fault_alarm, 1);
    m.put(3'h1);
    cyc(16);
    chk_out(hall_fault_alarm, 1);
    m.load(16'h0000, 7'h00, 8'h28);
    cyc(3);
    chk_out(angle_alarm, 0);
    m.load(16'h0000, 7'h00, 8'h29);
    cyc(3);
    chk_out(angle_alarm, 1);
    reset_dut();
    chk_out(hall_fault_alarm, 0);
    wr(RATED_OFS, 32'h0000_001E);
    ovl(40, 0, 0);
    ovl(1000, 50, 100);
    ovl(60, 25, 100);
    ovl(31 + $urandom_range(30), 10, 50);
    summarize();
  end
endmodule : tb
